// ===== common/sdram_pkg.sv
// Constants, register map and state codes for the SDRAM signal/refresh block
package sdram_pkg;
	localparam logic [7:0] ctrl_off = 8'h40;
	localparam logic [7:0] acr0_off = 8'h48;
	localparam logic [7:0] mask0_off = 8'h4c;
	localparam logic [7:0] acr1_off = 8'h50;
	localparam logic [7:0] mask1_off = 8'h54;
	localparam int no_addr_mux_bit = 13;
	localparam int clock_enable_as_command_bit = 12;
	localparam int sleep_rfsh_request_bit = 11;
	localparam int recov_hi = 10;
	localparam int recov_lo = 9;
	localparam int interval_hi = 8;
	localparam int interval_lo = 0;
	localparam int per_block_rfsh_on_bit = 15;
	localparam logic [15:0] ctrl_reset = 16'h0000;
	localparam logic [15:0] ctrl_wmask = 16'h3fff;
	localparam logic [31:0] acr_reset = 32'h0000_0000;
	localparam logic [31:0] acr_wmask = 32'hfffc_bfff;
	localparam logic [31:0] mask_reset = 32'h0000_0000;
	localparam logic [3:0] rcv_short = 4'h3;
	localparam logic [3:0] rcv_mid = 4'h6;
	localparam logic [3:0] rcv_long = 4'h9;
	localparam logic [3:0] interval_unit_low = 4'hf;
	localparam logic [1:0] resp_okay = 2'h0;
	localparam logic [1:0] resp_slverr = 2'h2;
	typedef enum logic [6:0] {
		st_idle  = 7'h01,
		st_act   = 7'h02,
		st_col   = 7'h04,
		st_ref   = 7'h08,
		st_rec   = 7'h10,
		st_sleep = 7'h20,
		st_wake  = 7'h40
	} state_t;
endpackage

// ===== core/sdram_ctrl.sv
// SDRAM pin sequencer, refresh timer and AXI4-Lite register file
`timescale 1ns/1ps
module sdram_ctrl #(
	parameter int addr_w = 24,
	parameter int col_bits = 9
) (
	input  wire logic              aclk,
	input  wire logic              aresetn,
	input  wire logic [7:0]        awaddr,
	input  wire logic              awvalid,
	output logic                   awready,
	input  wire logic [31:0]       wdata,
	input  wire logic [3:0]        wstrb,
	input  wire logic              wvalid,
	output logic                   wready,
	output logic [1:0]             bresp,
	output logic                   bvalid,
	input  wire logic              bready,
	input  wire logic [7:0]        araddr,
	input  wire logic              arvalid,
	output logic                   arready,
	output logic [31:0]            rdata,
	output logic [1:0]             rresp,
	output logic                   rvalid,
	input  wire logic              rready,
	input  wire logic              access_req,
	input  wire logic              access_write,
	input  wire logic              access_block,
	input  wire logic [3:0]        access_byte_en,
	input  wire logic [addr_w-1:0] access_addr,
	output logic                   access_done,
	output logic                   row_strobe_n,
	output logic                   column_strobe_n,
	output logic                   write_not_read,
	output logic [1:0]             block_select_n,
	output logic                   mem_clock_enable,
	output logic [3:0]             byte_lane_enable,
	output logic [addr_w-1:0]      mem_addr
);
	function automatic logic [31:0] merge(input logic [31:0] old,
		input logic [31:0] d, input logic [3:0] s);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (s[i]) begin
				r[i*8 +: 8] = d[i*8 +: 8];
			end
		end
		return r;
	endfunction

	// Reload value (rc+1)*16-1 needs no adder
	function automatic logic [12:0] reload(input logic [8:0] count);
		return {count, sdram_pkg::interval_unit_low};
	endfunction

	logic [15:0] ctl_reg, ctl_next;
	logic [31:0] acr0_reg, acr0_next, acr1_reg, acr1_next;
	logic [31:0] m0_reg, m0_next, m1_reg, m1_next;
	logic [7:0]  awa_reg, awa_next;
	logic [31:0] wd_reg, wd_next;
	logic [3:0]  ws_reg, ws_next;
	logic        awh_reg, awh_next, wh_reg, wh_next;
	logic        awready_next, wready_next, bvalid_next, arready_next;
	logic        rvalid_next;
	logic [1:0]  bresp_next, rresp_next;
	logic [31:0] rdata_next;
	logic        do_wr;

	always_comb begin
		awh_next = awh_reg | (awvalid & awready);
		wh_next = wh_reg | (wvalid & wready);
		awa_next = (awvalid & awready) ? awaddr : awa_reg;
		wd_next = (wvalid & wready) ? wdata : wd_reg;
		ws_next = (wvalid & wready) ? wstrb : ws_reg;
		bvalid_next = bvalid & ~bready;
		bresp_next = bresp;
		ctl_next = ctl_reg;
		acr0_next = acr0_reg;
		acr1_next = acr1_reg;
		m0_next = m0_reg;
		m1_next = m1_reg;
		do_wr = awh_next & wh_next & ~bvalid;
		if (do_wr) begin
			awh_next = 1'b0;
			wh_next = 1'b0;
			bvalid_next = 1'b1;
			bresp_next = sdram_pkg::resp_okay;
			unique case (awa_next)
			sdram_pkg::ctrl_off: ctl_next = 16'(merge(
				{16'h0000, ctl_reg}, wd_next, ws_next)) &
				sdram_pkg::ctrl_wmask;
			sdram_pkg::acr0_off: acr0_next = merge(acr0_reg, wd_next,
				ws_next) & sdram_pkg::acr_wmask;
			sdram_pkg::mask0_off: m0_next = merge(m0_reg, wd_next, ws_next);
			sdram_pkg::acr1_off: acr1_next = merge(acr1_reg, wd_next,
				ws_next) & sdram_pkg::acr_wmask;
			sdram_pkg::mask1_off: m1_next = merge(m1_reg, wd_next, ws_next);
			default: bresp_next = sdram_pkg::resp_slverr;
			endcase
		end
		awready_next = ~awh_next & ~bvalid_next;
		wready_next = ~wh_next & ~bvalid_next;
		rvalid_next = rvalid & ~rready;
		rdata_next = rdata;
		rresp_next = rresp;
		if (arvalid & arready) begin
			rvalid_next = 1'b1;
			rresp_next = sdram_pkg::resp_okay;
			unique case (araddr)
			sdram_pkg::ctrl_off: rdata_next = {16'h0000, ctl_reg};
			sdram_pkg::acr0_off: rdata_next = acr0_reg;
			sdram_pkg::mask0_off: rdata_next = m0_reg;
			sdram_pkg::acr1_off: rdata_next = acr1_reg;
			sdram_pkg::mask1_off: rdata_next = m1_reg;
			default: begin
				rdata_next = 32'h0000_0000;
				rresp_next = sdram_pkg::resp_slverr;
			end
			endcase
		end
		arready_next = ~rvalid_next;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctl_reg <= sdram_pkg::ctrl_reset;
			acr0_reg <= sdram_pkg::acr_reset;
			acr1_reg <= sdram_pkg::acr_reset;
			m0_reg <= sdram_pkg::mask_reset;
			m1_reg <= sdram_pkg::mask_reset;
			awa_reg <= 8'h00;
			wd_reg <= 32'h0000_0000;
			ws_reg <= 4'h0;
			awh_reg <= 1'b0;
			wh_reg <= 1'b0;
			awready <= 1'b0;
			wready <= 1'b0;
			bvalid <= 1'b0;
			bresp <= 2'h0;
			arready <= 1'b0;
			rvalid <= 1'b0;
			rdata <= 32'h0000_0000;
			rresp <= 2'h0;
		end else begin
			ctl_reg <= ctl_next;
			acr0_reg <= acr0_next;
			acr1_reg <= acr1_next;
			m0_reg <= m0_next;
			m1_reg <= m1_next;
			awa_reg <= awa_next;
			wd_reg <= wd_next;
			ws_reg <= ws_next;
			awh_reg <= awh_next;
			wh_reg <= wh_next;
			awready <= awready_next;
			wready <= wready_next;
			bvalid <= bvalid_next;
			bresp <= bresp_next;
			arready <= arready_next;
			rvalid <= rvalid_next;
			rdata <= rdata_next;
			rresp <= rresp_next;
		end
	end

	logic       no_mux, cke_cmd, is_req;
	logic [1:0] recov_sel;
	logic [1:0] rfsh_on;
	assign no_mux = ctl_reg[sdram_pkg::no_addr_mux_bit];
	assign cke_cmd = ctl_reg[sdram_pkg::clock_enable_as_command_bit];
	assign is_req = ctl_reg[sdram_pkg::sleep_rfsh_request_bit];
	assign recov_sel = ctl_reg[sdram_pkg::recov_hi:sdram_pkg::recov_lo];
	assign rfsh_on = {acr1_reg[sdram_pkg::per_block_rfsh_on_bit],
		acr0_reg[sdram_pkg::per_block_rfsh_on_bit]};

	sdram_pkg::state_t st_reg, st_next;
	logic [12:0] cnt_reg, cnt_next;
	logic        pend_reg, pend_next, served;
	logic [3:0]  rec_reg, rec_next, rcv;
	logic        wr_reg, wr_next, blk_reg, blk_next;
	logic [3:0]  be_reg, be_next;
	logic [addr_w-1:0] a_reg, a_next, addr_next;
	logic        ras_next, cas_next, wnr_next, cke_next, done_next;
	logic [1:0]  sel_next;
	logic [3:0]  lane_next;

	always_comb begin
		// One shared setting serves both blocks
		unique case (recov_sel)
		2'b00: rcv = sdram_pkg::rcv_short;
		2'b01: rcv = sdram_pkg::rcv_mid;
		default: rcv = sdram_pkg::rcv_long;
		endcase
		st_next = st_reg;
		rec_next = rec_reg;
		served = 1'b0;
		wr_next = wr_reg;
		blk_next = blk_reg;
		be_next = be_reg;
		a_next = a_reg;
		unique case (st_reg)
		sdram_pkg::st_idle: begin
			if (is_req && !cke_cmd) begin
				st_next = sdram_pkg::st_sleep;
			end else if (pend_reg) begin
				served = 1'b1;
				if (|rfsh_on) begin
					st_next = sdram_pkg::st_ref;
				end
			end else if (access_req) begin
				st_next = sdram_pkg::st_act;
				wr_next = access_write;
				blk_next = access_block;
				be_next = access_byte_en;
				a_next = access_addr;
			end
		end
		sdram_pkg::st_act: st_next = sdram_pkg::st_col;
		sdram_pkg::st_col: st_next = sdram_pkg::st_idle;
		sdram_pkg::st_ref: begin
			st_next = sdram_pkg::st_rec;
			rec_next = rcv - 4'h2;
		end
		sdram_pkg::st_rec: begin
			if (rec_reg == 4'h0) begin
				st_next = sdram_pkg::st_idle;
			end
			rec_next = rec_reg - 4'h1;
		end
		sdram_pkg::st_sleep: begin
			if (!is_req) begin
				st_next = sdram_pkg::st_wake;
			end
		end
		sdram_pkg::st_wake: st_next = sdram_pkg::st_idle;
		endcase
		// Counter frozen while the memories time their own refresh
		cnt_next = cnt_reg;
		pend_next = pend_reg & ~served;
		if (st_reg != sdram_pkg::st_sleep) begin
			if (cnt_reg == 13'h0000) begin
				cnt_next = reload(ctl_reg[sdram_pkg::interval_hi:
					sdram_pkg::interval_lo]);
				pend_next = 1'b1;
			end else begin
				cnt_next = cnt_reg - 13'h0001;
			end
		end
		ras_next = 1'b1;
		cas_next = 1'b1;
		wnr_next = 1'b0;
		sel_next = 2'b11;
		lane_next = 4'h0;
		cke_next = 1'b1;
		addr_next = mem_addr;
		done_next = 1'b0;
		unique case (st_next)
		sdram_pkg::st_act: begin
			ras_next = 1'b0;
			sel_next = blk_next ? 2'b01 : 2'b10;
			addr_next = a_next >> col_bits;
		end
		sdram_pkg::st_col: begin
			cas_next = 1'b0;
			wnr_next = wr_next;
			sel_next = blk_next ? 2'b01 : 2'b10;
			lane_next = be_next;
			addr_next = no_mux ? a_next : addr_w'(a_next[col_bits-1:0]);
			done_next = 1'b1;
		end
		sdram_pkg::st_ref: begin
			ras_next = 1'b0;
			cas_next = 1'b0;
			sel_next = ~rfsh_on;
		end
		sdram_pkg::st_sleep: begin
			cke_next = 1'b0;
			if (st_reg != sdram_pkg::st_sleep) begin
				ras_next = 1'b0;
				cas_next = 1'b0;
				sel_next = 2'b00;
			end
		end
		sdram_pkg::st_idle, sdram_pkg::st_rec, sdram_pkg::st_wake: ;
		endcase
		if (cke_cmd) begin
			// Command bit: high while a row is opened
			cke_next = (st_next == sdram_pkg::st_act);
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st_reg <= sdram_pkg::st_idle;
			cnt_reg <= 13'h0000;
			pend_reg <= 1'b0;
			rec_reg <= 4'h0;
			wr_reg <= 1'b0;
			blk_reg <= 1'b0;
			be_reg <= 4'h0;
			a_reg <= '0;
			row_strobe_n <= 1'b1;
			column_strobe_n <= 1'b1;
			write_not_read <= 1'b0;
			block_select_n <= 2'b11;
			mem_clock_enable <= 1'b1;
			byte_lane_enable <= 4'h0;
			mem_addr <= '0;
			access_done <= 1'b0;
		end else begin
			st_reg <= st_next;
			cnt_reg <= cnt_next;
			pend_reg <= pend_next;
			rec_reg <= rec_next;
			wr_reg <= wr_next;
			blk_reg <= blk_next;
			be_reg <= be_next;
			a_reg <= a_next;
			row_strobe_n <= ras_next;
			column_strobe_n <= cas_next;
			write_not_read <= wnr_next;
			block_select_n <= sel_next;
			mem_clock_enable <= cke_next;
			byte_lane_enable <= lane_next;
			mem_addr <= addr_next;
			access_done <= done_next;
		end
	end

	logic [3:0] since_ref;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			since_ref <= 4'hf;
		end else if (st_reg == sdram_pkg::st_ref) begin
			since_ref <= 4'h1;
		end else if (since_ref != 4'hf) begin
			since_ref <= since_ref + 4'h1;
		end
	end

	sequence enter_sleep_s;
		st_reg != sdram_pkg::st_sleep ##1 st_reg == sdram_pkg::st_sleep;
	endsequence
	sequence leave_sleep_s;
		st_reg == sdram_pkg::st_sleep && !is_req;
	endsequence

	row_open_a: assert property (@(posedge aclk) disable iff (!aresetn)
		st_reg == sdram_pkg::st_act |-> !row_strobe_n && column_strobe_n)
		else $error("activate without row strobe");
	col_strobe_a: assert property (@(posedge aclk) disable iff (!aresetn)
		st_reg == sdram_pkg::st_act |=> !column_strobe_n && row_strobe_n
		&& access_done)
		else $error("column strobe missing after activate");
	wnr_dir_a: assert property (@(posedge aclk) disable iff (!aresetn)
		st_reg == sdram_pkg::st_col |-> write_not_read == wr_reg)
		else $error("write_not_read wrong direction");
	one_select_a: assert property (@(posedge aclk) disable iff (!aresetn)
		!column_strobe_n && row_strobe_n |->
		block_select_n == (blk_reg ? 2'b01 : 2'b10))
		else $error("wrong block selected");
	lanes_idle_a: assert property (@(posedge aclk) disable iff (!aresetn)
		column_strobe_n |-> byte_lane_enable == 4'h0)
		else $error("byte lanes on outside transfer");
	col_mux_a: assert property (@(posedge aclk) disable iff (!aresetn)
		st_reg == sdram_pkg::st_col && !$past(no_mux) |->
		(mem_addr >> col_bits) == '0)
		else $error("column address not multiplexed");
	sleep_entry_a: assert property (@(posedge aclk) disable iff (!aresetn)
		enter_sleep_s |-> !row_strobe_n && !column_strobe_n
		&& block_select_n == 2'b00 && !mem_clock_enable)
		else $error("self refresh entry command wrong");
	sleep_exit_a: assert property (@(posedge aclk) disable iff (!aresetn)
		leave_sleep_s |=> mem_clock_enable ##1 st_reg == sdram_pkg::st_idle)
		else $error("self refresh exit missing");
	count_halt_a: assert property (@(posedge aclk) disable iff (!aresetn)
		st_reg == sdram_pkg::st_sleep |=> $stable(cnt_reg))
		else $error("interval counter ran in self refresh");
	ref_gap_a: assert property (@(posedge aclk) disable iff (!aresetn)
		st_reg == sdram_pkg::st_act |-> since_ref > rcv)
		else $error("activate too soon after refresh");
	rfsh_gate_a: assert property (@(posedge aclk) disable iff (!aresetn)
		st_reg == sdram_pkg::st_ref |-> block_select_n == ~$past(rfsh_on))
		else $error("refresh sent to disabled block");
	pend_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
		pend_reg && st_reg == sdram_pkg::st_act |=> pend_reg [*2])
		else $error("refresh request dropped");
endmodule // sdram_ctrl

// ===== tb/sdram_pins_model.sv
// Behavioural SDRAM pair decoding commands from the strobe pins
`timescale 1ns/1ps
module sdram_pins_model (
	input wire logic       aclk,
	input wire logic       row_strobe_n,
	input wire logic       column_strobe_n,
	input wire logic [1:0] block_select_n,
	input wire logic       mem_clock_enable
);
	int         cyc = 0;
	int         n_ref = 0;
	int         n_self = 0;
	int         n_exit = 0;
	int         ref_cyc = 0;
	int         period = 0;
	int         gap = 0;
	logic [1:0] ref_sel = 2'h3;
	logic       cke_d = 1'b1;
	logic       both;

	assign both = !row_strobe_n && !column_strobe_n;

	always @(posedge aclk) begin
		cyc <= cyc + 1;
		cke_d <= mem_clock_enable;
		// A refresh with no block selected never reaches a memory
		if (both && mem_clock_enable && block_select_n != 2'h3) begin
			n_ref <= n_ref + 1;
			period <= cyc - ref_cyc;
			ref_cyc <= cyc;
			ref_sel <= block_select_n;
		end
		if (both && !mem_clock_enable && block_select_n == 2'h0)
			n_self <= n_self + 1;
		if (mem_clock_enable && !cke_d)
			n_exit <= n_exit + 1;
		if (!row_strobe_n && column_strobe_n)
			gap <= cyc - ref_cyc;
	end
endmodule // sdram_pins_model

// ===== tb/test_sdram_signal_and_refresh_ctrl.sv
// Self-checking bench for the SDRAM pin sequencer and refresh timer
`timescale 1ns/1ps
module test_sdram_signal_and_refresh_ctrl;
	logic        aclk;
	logic        aresetn;
	logic [7:0]  awaddr;
	logic        awvalid;
	logic        awready;
	logic [31:0] wdata;
	logic [3:0]  wstrb;
	logic        wvalid;
	logic        wready;
	logic [1:0]  bresp;
	logic        bvalid;
	logic        bready;
	logic [7:0]  araddr;
	logic        arvalid;
	logic        arready;
	logic [31:0] rdata;
	logic [1:0]  rresp;
	logic        rvalid;
	logic        rready;
	logic        access_req;
	logic        access_write;
	logic        access_block;
	logic [3:0]  access_byte_en;
	logic [23:0] access_addr;
	logic        access_done;
	logic        row_strobe_n;
	logic        column_strobe_n;
	logic        write_not_read;
	logic [1:0]  block_select_n;
	logic        mem_clock_enable;
	logic [3:0]  byte_lane_enable;
	logic [23:0] mem_addr;
	int          n_mismatch = 0;
	int          num_checks = 0;

	typedef struct packed {
		logic [7:0]  a;
		logic [31:0] d;
		logic [31:0] q;
		logic [1:0]  r;
	} row_t;

	// Write data, expected read back and response per offset
	row_t rows [6] = '{
		'{8'h40, 32'hffff_f7ff, 32'h0000_37ff, 2'h0},
		'{8'h44, 32'hffff_ffff, 32'h0000_0000, 2'h2},
		'{8'h48, 32'hffff_ffff, 32'hfffc_bfff, 2'h0},
		'{8'h4c, 32'ha5a5_5a5a, 32'ha5a5_5a5a, 2'h0},
		'{8'h50, 32'h1234_8000, 32'h1234_8000, 2'h0},
		'{8'h54, 32'hffff_ffff, 32'hffff_ffff, 2'h0}};

	sdram_ctrl dut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
		.awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
		.wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
		.bready(bready), .araddr(araddr), .arvalid(arvalid),
		.arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
		.rready(rready), .access_req(access_req),
		.access_write(access_write), .access_block(access_block),
		.access_byte_en(access_byte_en), .access_addr(access_addr),
		.access_done(access_done), .row_strobe_n(row_strobe_n),
		.column_strobe_n(column_strobe_n), .write_not_read(write_not_read),
		.block_select_n(block_select_n), .mem_clock_enable(mem_clock_enable),
		.byte_lane_enable(byte_lane_enable), .mem_addr(mem_addr));

	sdram_pins_model m (.aclk(aclk), .row_strobe_n(row_strobe_n),
		.column_strobe_n(column_strobe_n), .block_select_n(block_select_n),
		.mem_clock_enable(mem_clock_enable));

	initial begin
		aclk = 0;
		forever #50 aclk = ~aclk;
	end

	task report_and_stop;
		$display("checks %0d mismatches %0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("wrong value at %0t: got %h exp %h", $time, got, exp);
		end
	endtask

	task give_up;
		n_mismatch++;
		$display("wrong value at %0t: wait expired %h %h", $time, 0, 1);
		report_and_stop;
	endtask

	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
			output logic [1:0] r);
		int n;
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1;
		wvalid <= 1;
		bready <= 1;
		for (n = 0; n < 50; n++) begin
			@(posedge aclk);
			if (awready === 1'b1)
				awvalid <= 0;
			if (wready === 1'b1)
				wvalid <= 0;
			if (bvalid === 1'b1)
				break;
		end
		if (n == 50)
			give_up;
		r = bresp;
		bready <= 0;
	endtask

	task automatic axi_rd(input logic [7:0] a, output logic [31:0] q,
			output logic [1:0] r);
		int n;
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1;
		rready <= 1;
		for (n = 0; n < 50; n++) begin
			@(posedge aclk);
			if (arready === 1'b1)
				arvalid <= 0;
			if (rvalid === 1'b1)
				break;
		end
		if (n == 50)
			give_up;
		q = rdata;
		r = rresp;
		rready <= 0;
	endtask

	task automatic put(input logic [7:0] a, input logic [31:0] d);
		logic [1:0] r;
		axi_wr(a, d, r);
		chk(r, 0);
	endtask

	task automatic wait_ref(input int k);
		int n;
		int s;
		s = m.n_ref;
		for (n = 0; n < 3000 && m.n_ref < s + k; n++)
			@(posedge aclk);
		if (n == 3000)
			give_up;
	endtask

	task automatic mem_acc(input logic w, input logic b, input logic [3:0] be,
			input logic [23:0] a, input logic no_mux);
		int n;
		@(posedge aclk);
		access_req <= 1;
		access_write <= w;
		access_block <= b;
		access_byte_en <= be;
		access_addr <= a;
		for (n = 0; n < 200; n++) begin
			@(posedge aclk);
			if (row_strobe_n === 1'b0 && column_strobe_n === 1'b1) begin
				chk(mem_addr, a >> 9);
				chk(block_select_n, b ? 2'h1 : 2'h2);
			end
			if (access_done === 1'b1)
				break;
		end
		if (n == 200)
			give_up;
		access_req <= 0;
		chk(column_strobe_n, 0);
		chk(write_not_read, w);
		chk(byte_lane_enable, be);
		chk(mem_addr, no_mux ? a : {15'h0, a[8:0]});
	endtask

	task do_reset;
		aresetn <= 0;
		repeat (16) @(posedge aclk);
		aresetn <= 1;
	endtask

	initial begin
		int i;
		int k;
		int s;
		int e;
		logic [31:0] q;
		logic [1:0] r;
		{aresetn, awaddr, awvalid, wdata, wvalid, bready} = '0;
		{araddr, arvalid, rready, access_req, access_write} = '0;
		{access_block, access_byte_en, access_addr} = '0;
		wstrb = 4'hf;
		do_reset;
		for (i = 0; i < 6; i++) begin
			axi_wr(rows[i].a, rows[i].d, r);
			chk(r, rows[i].r);
			axi_rd(rows[i].a, q, r);
			chk(q, rows[i].q);
			chk(r, rows[i].r);
		end
		$display("test registers done");
		do_reset;
		for (i = 0; i < 6; i++) begin
			axi_rd(rows[i].a, q, r);
			chk(q, 0);
		end
		$display("test reset done");
		// Refresh enables are off, so nothing breaks into these
		for (i = 0; i < 4; i++) begin
			if (i == 2)
				put(8'h40, 32'h2000);
			mem_acc(i[0], i[1], 4'h1 << i, 24'ha5c3f1 - 24'(i), i >= 2);
		end
		$display("test access done");
		put(8'h48, 32'h8000);
		put(8'h50, 32'h8000);
		put(8'h40, 32'h0001);
		wait_ref(3);
		chk(m.period, 32);
		chk(m.ref_sel, 2'h0);
		put(8'h50, 32'h0);
		wait_ref(2);
		chk(m.ref_sel, 2'h2);
		$display("test refresh done");
		for (i = 0; i < 4; i++) begin
			put(8'h40, 32'(i << 9) | 32'h1);
			wait_ref(1);
			mem_acc(0, i[0], 4'hf, 24'h000200, 0);
			k = (i == 0) ? 3 : (i == 1) ? 6 : 9;
			chk(m.gap > k && m.gap < k + 6, 1);
		end
		$display("test recovery done");
		put(8'h40, 32'h0);
		k = m.n_ref;
		// Back-to-back accesses must not starve the refresh timer
		for (i = 0; i < 8; i++)
			mem_acc(i[0], 0, 4'hf, 24'h000400 + 24'(i), 0);
		chk(m.n_ref > k, 1);
		$display("test refresh during access done");
		s = m.n_self;
		e = m.n_exit;
		put(8'h40, 32'h0801);
		for (i = 0; i < 20 && mem_clock_enable !== 1'b0; i++)
			@(posedge aclk);
		if (i == 20)
			give_up;
		@(posedge aclk);
		chk(m.n_self, s + 1);
		k = m.n_ref;
		// Six refresh periods would pass here if the timer ran on
		repeat (200) @(posedge aclk);
		chk(m.n_ref, k);
		chk(mem_clock_enable, 0);
		put(8'h40, 32'h0001);
		for (i = 0; i < 20 && mem_clock_enable !== 1'b1; i++)
			@(posedge aclk);
		if (i == 20)
			give_up;
		@(posedge aclk);
		chk(m.n_exit, e + 1);
		s = m.n_self;
		put(8'h40, 32'h1800);
		repeat (50) @(posedge aclk);
		chk(m.n_self, s);
		put(8'h40, 32'h0);
		$display("test self refresh done");
		report_and_stop;
	end
endmodule // test_sdram_signal_and_refresh_ctrl
